// ===== src/param_cmd_defines.svh
// Constants for the parameter command interpreter: opcodes, status codes,
// banks, frame layout and non-volatile map. Definitions only.
`ifndef PARAM_CMD_DEFINES_SVH
`define PARAM_CMD_DEFINES_SVH

// Instruction codes
`define CMD_READ_AXIS     8'h06
`define CMD_STORE_AXIS    8'h07
`define CMD_RESTORE_AXIS  8'h08
`define CMD_SET_GLOBAL    8'h09
`define CMD_GET_GLOBAL    8'h0A
`define CMD_STORE_GLOBAL  8'h0B

// Reply status codes
`define ST_OK             8'h64
`define ST_BAD_CMD        8'h02
`define ST_BAD_TYPE       8'h03
`define ST_BAD_VALUE      8'h04

// Banks of global parameters
`define BANK_GLOBAL       8'h00
`define BANK_USER         8'h02
`define BANK_IRQ          8'h03

// Parameter numbering
`define PARAM_N           16
`define IDX_W             4
`define HI_AXIS           4'h0
`define HI_GLOB           4'h4
`define AXIS_ACTPOS       8'h01
`define ADDR_IDX          4'h2
`define DEF_MODULE_ADDR   32'h0000_0001

// Frame layout: eight bytes held, ninth is the checksum
`define FRAME_LAST        4'h8

// Non-volatile map: region in addr[5:4], index in addr[3:0]
`define NV_AW             6
`define NV_DEPTH          64
`define NV_AXIS           2'h0
`define NV_GLOB           2'h1
`define NV_USER           2'h2
`define NV_LAST           6'h2F
// Edges of the power-up walk, one per stored entry
`define RESTORE_CYC       6'h30

`endif

// ===== src/param_cmd_pkg.sv
// Types shared by the command interpreter and its non-volatile store.
// Assumes param_cmd_defines.svh is on the include path.
`include "param_cmd_defines.svh"

package param_cmd_pkg;

   typedef logic [7:0]  byte_t;
   typedef logic [31:0] word_t;

   typedef enum logic [1:0] {
      ST_RESTORE,
      ST_IDLE,
      ST_EXEC
   } state_e;

   typedef struct packed {
      state_e                         st;
      logic [`NV_AW-1:0]              cnt;
      logic [3:0]                     nbyte;
      logic [7:0][7:0]                frame;
      byte_t                          sum;
      logic [`PARAM_N-1:0][31:0]      axis;
      logic [`PARAM_N-1:0][31:0]      glob0;
      logic [`PARAM_N-1:0][31:0]      user;
      logic [`PARAM_N-1:0][31:0]      irq;
      word_t                          accum;
      logic                           rvalid;
      byte_t                          rstat;
      byte_t                          rcmd;
      word_t                          rval;
   } core_s;

   typedef struct packed {
      logic [`NV_DEPTH-1:0][31:0]     mem;
   } nv_s;

endpackage

// ===== src/nv_port_if.sv
// Port between the interpreter core and its non-volatile store.
// Read is combinational from the store's flip-flops; write takes one edge.
`timescale 1ns/1ps
`include "param_cmd_defines.svh"

interface nv_port_if;
   logic              wr_en;
   logic [`NV_AW-1:0] addr;
   logic [31:0]       wr_data;
   logic [31:0]       rd_data;

   modport core (output wr_en, output addr, output wr_data, input rd_data);
   modport mem  (input wr_en, input addr, input wr_data, output rd_data);
endinterface

// ===== src/param_nv_store.sv
// Non-volatile copy of axis parameters, bank 0 settings and user variables.
// Assumes a reset that is already synchronised; reset means power-up defaults.
`timescale 1ns/1ps
`include "param_cmd_defines.svh"

module param_nv_store (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   // Store port
   nv_port_if.mem    nv
);
   import param_cmd_pkg::*;

   nv_s q;
   nv_s d;

   // Blank store holds zeros except the module address default
   always_comb begin
      d = q;
      if (nv.wr_en) begin
         d.mem[nv.addr] = nv.wr_data;
      end
   end

   // Read needs no wait, so a restore completes in the same cycle
   assign nv.rd_data = q.mem[nv.addr];

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.mem[{`NV_GLOB, `ADDR_IDX}] <= `DEF_MODULE_ADDR;
      end else begin
         q <= d;
      end
   end

endmodule

// ===== src/parameter_command_interpreter.sv
// Command interpreter for parameter access over a framed byte link.
// Assumes bytes arrive from a receiver on clk_sys_i, one per rx_valid_i.
`timescale 1ns/1ps
`include "param_cmd_defines.svh"

// How it works
// - Opcode 6 reads axis parameter type
// - Standalone read also loads accumulator
// - Direct read leaves accumulator untouched
// - Read replies status 100 with value
// - Opcode 7 stores axis parameter, zero reply
// - Opcode 8 reloads axis parameter from store
// - Power-up restores all stored parameters
// - Opcode 9 sets global, banks 0/2/3
// - Bank 0 settings, 2 user, 3 interrupts
// - Bank 0 writes commit to store
// - Set global replies status 100
// - Opcode 10 loads global into accumulator
// - Get global replies 100 with value
// - Global 66 bank 0 is link address
// - Axis parameter 1 is actual position
// - Store global saves bank 2 variable
// - Opcode 11, bank 2, value ignored
module parameter_command_interpreter (
   // Clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_n_i,
   // Incoming frame bytes
   input  wire param_cmd_pkg::byte_t rx_byte_i,
   input  wire logic                 rx_valid_i,
   output logic                      rx_ready_o,
   // Mode and motor state
   input  wire logic                 standalone_i,
   input  wire param_cmd_pkg::word_t actual_pos_i,
   // Reply
   output logic                      reply_valid_o,
   output param_cmd_pkg::byte_t      reply_status_o,
   output param_cmd_pkg::byte_t      reply_cmd_o,
   output param_cmd_pkg::word_t      reply_value_o,
   // State views
   output param_cmd_pkg::word_t      accum_o,
   output param_cmd_pkg::byte_t      module_addr_o
);
   import param_cmd_pkg::*;

   logic [1:0] rst_sync_q;
   logic       rst_n;
   core_s      q;
   core_s      d;
   nv_port_if  nv ();

   // Reset release through two flops; assertion is immediate
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Fields of the held frame: addr, instr, type, bank, value[3:0]
   byte_t                 f_instr;
   byte_t                 f_type;
   byte_t                 f_bank;
   word_t                 f_value;
   logic [`IDX_W-1:0]     idx;
   logic                  axis_ok;
   assign f_instr = q.frame[6];
   assign f_type  = q.frame[5];
   assign f_bank  = q.frame[4];
   assign f_value = q.frame[3:0];
   assign idx     = f_type[`IDX_W-1:0];
   assign axis_ok = (f_type[7:4] == `HI_AXIS) && (f_bank == `BANK_GLOBAL);

   // Next state: restore walk, frame gathering, one-cycle execution
   always_comb begin
      byte_t stat;
      word_t rv;
      stat       = `ST_OK;
      rv         = '0;
      d          = q;
      d.rvalid   = 1'b0;
      nv.wr_en   = 1'b0;
      nv.addr    = q.cnt;
      nv.wr_data = '0;
      unique case (q.st)
         ST_RESTORE: begin
            // Walks every stored entry once before any frame is taken
            if (q.cnt[5:4] == `NV_AXIS) begin
               d.axis[q.cnt[3:0]] = nv.rd_data;
            end else if (q.cnt[5:4] == `NV_GLOB) begin
               d.glob0[q.cnt[3:0]] = nv.rd_data;
            end else begin
               d.user[q.cnt[3:0]] = nv.rd_data;
            end
            d.cnt = q.cnt + 6'h01;
            if (q.cnt == `NV_LAST) begin
               d.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (rx_valid_i) begin
               if (q.nbyte == `FRAME_LAST) begin
                  d.nbyte = '0;
                  d.sum   = '0;
                  // Foreign or corrupt frames vanish without a reply
                  if (rx_byte_i == q.sum && q.frame[7] == q.glob0[`ADDR_IDX][7:0]) begin
                     d.st = ST_EXEC;
                  end
               end else begin
                  d.frame = {q.frame[6:0], rx_byte_i};
                  d.sum   = q.sum + rx_byte_i;
                  d.nbyte = q.nbyte + 4'h1;
               end
            end
         end
         ST_EXEC: begin
            case (f_instr)
               `CMD_READ_AXIS: begin
                  if (!axis_ok) begin
                     stat = `ST_BAD_TYPE;
                  end else begin
                     // Position comes live from the motion logic
                     rv = (f_type == `AXIS_ACTPOS) ? actual_pos_i : q.axis[idx];
                     if (standalone_i) begin
                        d.accum = rv;
                     end
                  end
               end
               `CMD_STORE_AXIS: begin
                  if (!axis_ok) begin
                     stat = `ST_BAD_TYPE;
                  end else begin
                     nv.wr_en   = 1'b1;
                     nv.addr    = {`NV_AXIS, idx};
                     nv.wr_data = q.axis[idx];
                  end
               end
               `CMD_RESTORE_AXIS: begin
                  if (!axis_ok) begin
                     stat = `ST_BAD_TYPE;
                  end else begin
                     nv.addr      = {`NV_AXIS, idx};
                     d.axis[idx] = nv.rd_data;
                  end
               end
               `CMD_SET_GLOBAL: begin
                  // Bank selects which group is written
                  if (f_bank == `BANK_GLOBAL && f_type[7:4] == `HI_GLOB) begin
                     d.glob0[idx] = f_value;
                     nv.wr_en     = 1'b1;
                     nv.addr      = {`NV_GLOB, idx};
                     nv.wr_data   = f_value;
                  end else if (f_bank == `BANK_USER && f_type[7:4] == `HI_AXIS) begin
                     d.user[idx] = f_value;
                  end else if (f_bank == `BANK_IRQ && f_type[7:4] == `HI_AXIS) begin
                     d.irq[idx] = f_value;
                  end else if (f_bank == `BANK_GLOBAL || f_bank == `BANK_USER ||
                               f_bank == `BANK_IRQ) begin
                     stat = `ST_BAD_TYPE;
                  end else begin
                     stat = `ST_BAD_VALUE;
                  end
               end
               `CMD_GET_GLOBAL: begin
                  if (f_bank == `BANK_GLOBAL && f_type[7:4] == `HI_GLOB) begin
                     rv = q.glob0[idx];
                  end else if (f_bank == `BANK_USER && f_type[7:4] == `HI_AXIS) begin
                     rv = q.user[idx];
                  end else if (f_bank == `BANK_IRQ && f_type[7:4] == `HI_AXIS) begin
                     rv = q.irq[idx];
                  end else begin
                     stat = `ST_BAD_TYPE;
                  end
                  if (stat == `ST_OK) begin
                     d.accum = rv;
                  end
               end
               `CMD_STORE_GLOBAL: begin
                  // Only user variables need an explicit store
                  if (f_bank == `BANK_USER && f_type[7:4] == `HI_AXIS) begin
                     nv.wr_en   = 1'b1;
                     nv.addr    = {`NV_USER, idx};
                     nv.wr_data = q.user[idx];
                  end else begin
                     stat = `ST_BAD_VALUE;
                  end
               end
               default: begin
                  stat = `ST_BAD_CMD;
               end
            endcase
            d.rvalid = 1'b1;
            d.rstat  = stat;
            d.rcmd   = f_instr;
            d.rval   = rv;
            d.st     = ST_IDLE;
         end
      endcase
   end

   // Single state register for the whole core
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.glob0[`ADDR_IDX] <= `DEF_MODULE_ADDR;
      end else begin
         q <= d;
      end
   end

   param_nv_store u_nv (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .nv        (nv.mem)
   );

   // Outputs; ready drops during restore and execution
   assign rx_ready_o     = (q.st == ST_IDLE);
   assign reply_valid_o  = q.rvalid;
   assign reply_status_o = q.rstat;
   assign reply_cmd_o    = q.rcmd;
   assign reply_value_o  = q.rval;
   assign accum_o        = q.accum;
   assign module_addr_o  = q.glob0[`ADDR_IDX][7:0];

   // Edges since the internal reset let go, stuck at its top; read by checks only
   logic [`NV_AW-1:0] since_rst_q;
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         since_rst_q <= '0;
      end else if (since_rst_q != '1) begin
         since_rst_q <= since_rst_q + 6'h01;
      end
   end

   // Checks
   sequence exec_s(byte_t op);
      q.st == ST_EXEC && f_instr == op;
   endsequence

   sequence last_bad_s;
      q.st == ST_IDLE && rx_valid_i && q.nbyte == `FRAME_LAST && rx_byte_i != q.sum;
   endsequence

   a_read_actpos: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_READ_AXIS) ##0 (f_type == `AXIS_ACTPOS && axis_ok) |=>
         reply_valid_o && reply_status_o == `ST_OK && reply_value_o == $past(actual_pos_i))
      else $error("read of actual position gave wrong reply");

   a_accum_direct: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_READ_AXIS) ##0 !standalone_i |=> $stable(accum_o))
      else $error("direct-mode read changed the accumulator");

   a_accum_standalone: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_READ_AXIS) ##0 (standalone_i && axis_ok) |=> accum_o == reply_value_o)
      else $error("standalone read did not load the accumulator");

   a_store_axis: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_STORE_AXIS) ##0 axis_ok |-> nv.wr_en ##1 (reply_value_o == '0 &&
         reply_status_o == `ST_OK))
      else $error("axis store did not write the store or reply zero");

   a_glob0_commit: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_SET_GLOBAL) ##0 (f_bank == `BANK_GLOBAL && f_type[7:4] == `HI_GLOB) |->
         nv.wr_en && nv.addr[5:4] == `NV_GLOB ##1 reply_status_o == `ST_OK)
      else $error("bank 0 setting not committed");

   a_get_glob: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_GET_GLOBAL) ##0 (f_bank == `BANK_GLOBAL && f_type == {`HI_GLOB, `ADDR_IDX}) |=>
         reply_value_o == {24'h0, module_addr_o} && accum_o == reply_value_o)
      else $error("get of link address gave wrong value");

   a_restore_walk: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      since_rst_q <= `RESTORE_CYC |-> rx_ready_o == (since_rst_q == `RESTORE_CYC))
      else $error("ready did not follow the power-up restore walk");

   a_bad_sum_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      last_bad_s |=> rx_ready_o && !reply_valid_o ##1 !reply_valid_o)
      else $error("frame with bad checksum was answered");

   a_reply_once: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      reply_valid_o |=> !reply_valid_o && rx_ready_o)
      else $error("reply lasted more than one cycle");

   a_store_user: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_STORE_GLOBAL) ##0 (f_bank == `BANK_USER && f_type[7:4] == `HI_AXIS) |->
         nv.wr_en && nv.addr == {`NV_USER, idx} && nv.wr_data == q.user[idx])
      else $error("user variable store did not reach the store");

   a_user_volatile: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_SET_GLOBAL) ##0 (f_bank != `BANK_GLOBAL) |-> !nv.wr_en)
      else $error("user or interrupt setting written to the store");

   a_restore_axis: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      exec_s(`CMD_RESTORE_AXIS) ##0 axis_ok |->
         nv.addr == {`NV_AXIS, idx} ##1 q.axis[$past(idx)] == $past(nv.rd_data))
      else $error("axis restore did not reload the stored copy");

   a_reply_echo: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      q.st == ST_EXEC |=> reply_valid_o && reply_cmd_o == $past(f_instr))
      else $error("reply does not carry the instruction it answers");

endmodule

// ===== tb/host_frame_model.sv
// Host side of the byte link: offers nine-byte frames, one byte per take.
// Assumes the interpreter takes a byte on a rising edge with ready high.
`timescale 1ns/1ps

module host_frame_model (
   // Clock
   input  wire logic            clk_sys_i,
   // Link towards the interpreter
   input  wire logic            rx_ready_i,
   output param_cmd_pkg::byte_t rx_byte_o,
   output logic                 rx_valid_o
);
   import param_cmd_pkg::*;

   // Idle cycles allowed between bytes, set by the bench
   int unsigned gap_max = 0;

   // Released line inverts its pattern each gap cycle inside a frame, so it can show the last byte again
   initial begin
      rx_byte_o  = 8'hA5;
      rx_valid_o = 1'b0;
   end

   // Offer one frame; a bad sum is sent only when asked for
   task automatic send_frame(input byte_t fb [8], input bit bad_sum);
      byte_t sum;
      byte_t b;
      logic  rdy;
      sum = 8'h00;
      @(posedge clk_sys_i);
      for (int i = 0; i < 9; i++) begin
         if (i < 8) begin
            b   = fb[i];
            sum = sum + fb[i];
         end else begin
            b = bad_sum ? ~sum : sum;
         end
         repeat ((gap_max == 0) ? 0 : $urandom_range(gap_max)) begin
            rx_valid_o <= 1'b0;
            rx_byte_o  <= ~rx_byte_o;
            @(posedge clk_sys_i);
         end
         // Hold byte and valid until ready is seen at an edge
         rx_byte_o  <= b;
         rx_valid_o <= 1'b1;
         do begin
            @(negedge clk_sys_i);
            rdy = rx_ready_i;
            @(posedge clk_sys_i);
         end while (rdy !== 1'b1);
      end
      rx_valid_o <= 1'b0;
      rx_byte_o  <= ~b;
   endtask
endmodule

// ===== tb/parameter_command_interpreter_tb_top.sv
// Bench: host model sends frames, a reference model predicts each reply.
// Assumes the design's own reset synchroniser and a 100 MHz clock.
`timescale 1ns/1ps

module parameter_command_interpreter_tb_top;
   import param_cmd_pkg::*;

   // Design signals
   logic  clk_sys_i, rst_n_i, rx_valid_i, rx_ready_o, standalone_i, reply_valid_o;
   byte_t rx_byte_i, reply_status_o, reply_cmd_o, module_addr_o;
   word_t actual_pos_i, reply_value_o, accum_o;
   // Reference state: global banks by bank number, axis working and stored copies
   word_t gm [4][16];
   word_t axis_m [16];
   word_t nv_axis [16];
   word_t accum_m;
   int    fail_count = 0;
   int    tests_run  = 0;
   int    cycles     = 0;
   // Refused cases: opcode, type, bank
   byte_t errs [9][3] = '{'{8'h06, 8'h10, 8'h00}, '{8'h06, 8'h01, 8'h01},
      '{8'h09, 8'h05, 8'h01}, '{8'h09, 8'h05, 8'h00}, '{8'h0B, 8'h03, 8'h00},
      '{8'h0C, 8'h00, 8'h00}, '{8'h0A, 8'h14, 8'h02}, '{8'h0B, 8'h13, 8'h02},
      '{8'h0A, 8'h02, 8'h01}};
   byte_t banks [3] = '{8'h00, 8'h02, 8'h03};

   parameter_command_interpreter i_parameter_command_interpreter (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_byte_i(rx_byte_i),
      .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .standalone_i(standalone_i),
      .actual_pos_i(actual_pos_i), .reply_valid_o(reply_valid_o),
      .reply_status_o(reply_status_o), .reply_cmd_o(reply_cmd_o),
      .reply_value_o(reply_value_o), .accum_o(accum_o), .module_addr_o(module_addr_o));

   host_frame_model i_host_frame_model (
      .clk_sys_i(clk_sys_i), .rx_ready_i(rx_ready_o), .rx_byte_o(rx_byte_i),
      .rx_valid_o(rx_valid_i));

   // Clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Hang guard, well above the roughly 1500 cycles the run needs
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Reset clears the store too, so restore brings back defaults
   task automatic do_reset();
      int n;
      rst_n_i <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      gm      = '{default: '0};
      axis_m  = '{default: '0};
      nv_axis = '{default: '0};
      gm[0][2] = 32'h0000_0001;
      accum_m  = '0;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (rx_ready_o !== 1'b1 && n < 200);
      check(n >= 48 && n < 200, 1);
      check(accum_o, 32'h0);
      check(module_addr_o, 8'h01);
   endtask

   // One frame through the link, predicted then compared
   task automatic do_cmd(input byte_t adr, op, typ, bnk, input word_t val,
                         input logic sa, input word_t pos, input bit bad);
      byte_t fb [8];
      byte_t st;
      word_t rv;
      int    ix;
      bit    hit;
      bit    seen;
      fb  = '{adr, op, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0]};
      hit = !bad && adr == gm[0][2][7:0];
      st  = 8'h64;
      rv  = '0;
      ix  = (bnk == 8'h00) ? int'(typ) - 64 : int'(typ);
      if (op == 8'h06 || op == 8'h07 || op == 8'h08) begin
         if (bnk != 8'h00 || typ > 8'h0F) st = 8'h03;
      end else if (op == 8'h09 || op == 8'h0A) begin
         if (!(bnk inside {8'h00, 8'h02, 8'h03})) st = (op == 8'h09) ? 8'h04 : 8'h03;
         else if (ix < 0 || ix > 15) st = 8'h03;
      end else if (op == 8'h0B) begin
         if (bnk != 8'h02) st = 8'h04;
         else if (typ > 8'h0F) st = 8'h04;
      end else begin
         st = 8'h02;
      end
      if (hit && st == 8'h64) begin
         case (op)
            8'h06: begin
               rv = (typ == 8'h01) ? pos : axis_m[typ];
               if (sa) accum_m = rv;
            end
            8'h07: nv_axis[typ] = axis_m[typ];
            8'h08: axis_m[typ] = nv_axis[typ];
            8'h09: gm[bnk][ix] = val;
            8'h0A: begin
               rv      = gm[bnk][ix];
               accum_m = rv;
            end
            default: ;
         endcase
      end
      @(posedge clk_sys_i);
      standalone_i <= sa;
      actual_pos_i <= pos;
      i_host_frame_model.send_frame(fb, bad);
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++) begin
         @(negedge clk_sys_i);
         seen = (reply_valid_o === 1'b1);
      end
      check(seen, hit);
      if (seen) begin
         check(reply_status_o, st);
         check(reply_cmd_o, op);
         check(reply_value_o, rv);
      end
      @(negedge clk_sys_i);
      check(accum_o, accum_m);
      check(module_addr_o, gm[0][2][7:0]);
   endtask

   // Main sequence
   initial begin
      byte_t op, typ, bnk;
      rst_n_i      = 1'b0;
      standalone_i = 1'b0;
      actual_pos_i = '0;
      void'($urandom(88));
      do_reset();
      do_cmd(8'h01, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0, 32'h0, 1'b0);
      do_cmd(8'h01, 8'h06, 8'h01, 8'h00, 32'h0, 1'b0, 32'h1234_5678, 1'b0);
      do_cmd(8'h01, 8'h06, 8'h01, 8'h00, 32'h0, 1'b1, 32'h8765_4321, 1'b0);
      foreach (errs[k]) begin
         do_cmd(8'h01, errs[k][0], errs[k][1], errs[k][2], 32'h5, 1'b1, 32'h9, 1'b0);
      end
      do_cmd(8'h01, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0, 32'h0, 1'b1);
      do_cmd(8'h05, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0, 32'h0, 1'b0);
      do_cmd(8'h01, 8'h09, 8'h42, 8'h00, 32'h3, 1'b0, 32'h0, 1'b0);
      do_cmd(8'h03, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0, 32'h0, 1'b0);
      // Random mix of all six opcodes, address 66 kept out
      for (int n = 0; n < 60; n++) begin
         op  = 8'h06 + 8'($urandom_range(5));
         bnk = (op == 8'h0B) ? 8'h02 : 8'h00;
         if (op == 8'h09 || op == 8'h0A) bnk = banks[$urandom_range(2)];
         typ = 8'($urandom_range(15));
         if (bnk == 8'h00 && op > 8'h08) typ = (typ == 8'h02) ? 8'h4F : typ + 8'h40;
         if ((op == 8'h07 || op == 8'h08) && typ == 8'h01) typ = 8'h02;
         i_host_frame_model.gap_max = n % 3;
         do_cmd(gm[0][2][7:0], op, typ, bnk, $urandom, 1'($urandom), $urandom,
                1'b0);
      end
      // Reset in mid-run brings back the power-up values
      do_cmd(8'h03, 8'h09, 8'h03, 8'h02, 32'hCAFE_0001, 1'b0, 32'h0, 1'b0);
      do_reset();
      do_cmd(8'h01, 8'h0A, 8'h03, 8'h02, 32'h0, 1'b0, 32'h0, 1'b0);
      print_verdict();
   end
endmodule
